// ### hdl/drc_dec_fmt.sv
// Serial signed decimal formatter that emits one ASCII character per handshake.
`timescale 1ns/100ps
module drc_dec_fmt (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [31:0] value,
    input wire logic ch_take,
    output logic [7:0] ch,
    output logic ch_valid,
    output logic busy
);
    logic [31:0] mag;
    logic [3:0] pos;
    logic [3:0] dig;
    logic lead;
    logic neg_pend;
    logic last;
    logic [31:0] pw;
    logic ge;
    logic show;

    assign pw = drc_pkg::drc_pow10(pos);
    assign ge = mag >= pw;
    assign show = (dig != 4'h0) || lead || (pos == 4'h0);

    // ------------------------------------------------------------------
    // Digit generation by repeated subtraction of powers of ten
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mag <= 32'h0;
            pos <= 4'h0;
            dig <= 4'h0;
            lead <= 1'b0;
            neg_pend <= 1'b0;
            last <= 1'b0;
            ch <= 8'h0;
            ch_valid <= 1'b0;
            busy <= 1'b0;
        end else if (start) begin
            mag <= value[31] ? 32'(-value) : value;
            neg_pend <= value[31];
            pos <= 4'h9;
            dig <= 4'h0;
            lead <= 1'b0;
            last <= 1'b0;
            ch_valid <= 1'b0;
            busy <= 1'b1;
        end else if (ch_valid) begin
            if (ch_take) begin
                ch_valid <= 1'b0;
                busy <= !last;
            end
        end else if (busy) begin
            if (neg_pend) begin
                ch <= drc_pkg::CH_MINUS;
                ch_valid <= 1'b1;
                neg_pend <= 1'b0;
            end else if (ge) begin
                mag <= mag - pw;
                dig <= dig + 4'h1;
            end else if (show) begin
                ch <= drc_pkg::CH_ZERO + {4'h0, dig};
                ch_valid <= 1'b1;
                lead <= 1'b1;
                dig <= 4'h0;
                last <= (pos == 4'h0);
                pos <= (pos == 4'h0) ? 4'h0 : pos - 4'h1;
            end else begin
                pos <= pos - 4'h1;
            end
        end
    end
endmodule : drc_dec_fmt

// ### hdl/drc_handler.sv
// Command handler for register copy, non-volatile load and store, status, upload and version.
`timescale 1ns/100ps
module drc_handler #(
    parameter logic [63:0] RO_MASK = 64'hFFFF_0000_0000_0000,
    parameter logic [63:0] SHORT_MASK = 64'h0000_FFFF_0000_0000,
    parameter logic [31:0] FW_VERSION = 32'h64
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire drc_pkg::drc_cmd_t cmd,
    input wire drc_pkg::drc_status_t status,
    input wire logic [15:0] host_option,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic cmd_done,
    output logic cmd_reject,
    output logic ar_enable,
    output logic ar_nv_wr,
    output logic nv_wr,
    input wire logic [5:0] dbg_idx,
    output logic [31:0] dbg_data
);
    drc_pkg::drc_state_t state;
    drc_pkg::drc_cmd_t lc;
    logic [31:0] regs [drc_pkg::NREG];
    logic [31:0] nv [drc_pkg::NV_DEPTH];
    logic [5:0] cur, ia, ib;
    logic [4:0] left;
    logic [1:0] name_idx;
    logic [3:0] stat_idx;
    logic [11:0] st_vec;
    logic free, a_ok, a_wr, b_wr, loc_ok, cnt_ok, cmd_ok, numeric, exec;
    logic [6:0] loc;
    logic [31:0] copy_val, load_val, fmt_value;
    logic [7:0] name_char, code_tens, code_ones, fmt_ch;
    logic fmt_start, fmt_take, fmt_valid, fmt_busy;

    // ------------------------------------------------------------------
    // Decoding and range checks
    // ------------------------------------------------------------------
    assign ia = lc.reg_a[5:0];
    assign ib = lc.reg_b[5:0];
    assign loc = 7'(lc.arg - 32'h1);
    assign free = !tx_valid || tx_ready;
    assign exec = state == drc_pkg::DRC_EXEC;
    assign cmd_ready = state == drc_pkg::DRC_IDLE;
    assign numeric = host_option[drc_pkg::OPT_NUMERIC_BIT];
    assign st_vec = status;
    assign a_ok = lc.reg_a < 8'(drc_pkg::NREG);
    assign a_wr = a_ok && !RO_MASK[ia];
    assign b_wr = (lc.reg_b < 8'(drc_pkg::NREG)) && !RO_MASK[ib];
    assign loc_ok = lc.arg >= drc_pkg::NV_LOC_MIN && lc.arg <= drc_pkg::NV_LOC_MAX;
    assign cnt_ok = lc.arg >= drc_pkg::UPLOAD_MIN && lc.arg <= drc_pkg::UPLOAD_MAX
        && ({24'h0, lc.reg_a} + lc.arg) <= 32'(drc_pkg::NREG);
    assign cmd_ok =
        (lc.op == drc_pkg::DRC_COPY_REGISTER_CMD) ? (a_ok && b_wr) :
        (lc.op == drc_pkg::DRC_NV_LOAD_CMD) ? (a_wr && loc_ok) :
        (lc.op == drc_pkg::DRC_NV_STORE_CMD) ? (a_wr && loc_ok) :
        (lc.op == drc_pkg::DRC_ANTIRESONANCE_CMD) ? (!lc.has_arg || lc.arg[31:1] == 31'h0) :
        (lc.op == drc_pkg::DRC_BLOCK_UPLOAD_CMD) ? (a_ok && cnt_ok) : 1'b1;
    assign copy_val = SHORT_MASK[ib] ? {{16{regs[ia][15]}}, regs[ia][15:0]} : regs[ia];
    assign load_val = SHORT_MASK[ia] ? {{16{nv[loc][15]}}, nv[loc][15:0]} : nv[loc];
    assign name_char = drc_pkg::CH_ZERO + {2'h0, cur};
    assign code_tens = drc_pkg::CH_ZERO + 8'({2'h0, cur} / 8'hA);
    assign code_ones = drc_pkg::CH_ZERO + 8'({2'h0, cur} % 8'hA);
    assign fmt_value =
        (lc.op == drc_pkg::DRC_BLOCK_UPLOAD_CMD) ? regs[cur] :
        (lc.op == drc_pkg::DRC_ANTIRESONANCE_CMD) ? {31'h0, ar_enable} : FW_VERSION;
    assign fmt_start = state == drc_pkg::DRC_EQ && free && lc.op != drc_pkg::DRC_STATUS_QUERY_CMD;
    assign fmt_take = state == drc_pkg::DRC_VAL && fmt_valid && free;
    drc_dec_fmt u_fmt (.ref_clk(ref_clk), .rst_b(rst_b), .start(fmt_start), .value(fmt_value),
        .ch_take(fmt_take), .ch(fmt_ch), .ch_valid(fmt_valid), .busy(fmt_busy));

    // ------------------------------------------------------------------
    // Register file and non-volatile store
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < drc_pkg::NREG; i++) begin
                regs[i] <= drc_pkg::REG_RESET;
            end
        end else if (exec && cmd_ok && lc.op == drc_pkg::DRC_COPY_REGISTER_CMD) begin
            regs[ib] <= copy_val;
        end else if (exec && cmd_ok && lc.op == drc_pkg::DRC_NV_LOAD_CMD) begin
            regs[ia] <= load_val;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (exec && cmd_ok && lc.op == drc_pkg::DRC_NV_STORE_CMD) begin
            nv[loc] <= regs[ia];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dbg_data <= 32'h0;
        end else begin
            dbg_data <= regs[dbg_idx];
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer and reply generator
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= drc_pkg::DRC_IDLE;
            lc <= '0;
            cur <= 6'h0;
            left <= 5'h0;
            name_idx <= 2'h0;
            stat_idx <= 4'h0;
            tx_data <= 8'h0;
            tx_valid <= 1'b0;
            cmd_done <= 1'b0;
            cmd_reject <= 1'b0;
            ar_enable <= drc_pkg::AR_RESET[0];
            ar_nv_wr <= 1'b0;
            nv_wr <= 1'b0;
        end else begin
            cmd_done <= 1'b0;
            cmd_reject <= 1'b0;
            ar_nv_wr <= 1'b0;
            nv_wr <= 1'b0;
            tx_valid <= tx_valid && !tx_ready;
            case (state)
                drc_pkg::DRC_IDLE: begin
                    if (cmd_valid) begin
                        lc <= cmd;
                        state <= drc_pkg::DRC_EXEC;
                    end
                end
                drc_pkg::DRC_EXEC: begin
                    cur <= ia;
                    left <= lc.arg[4:0];
                    name_idx <= 2'h0;
                    stat_idx <= drc_pkg::STAT_LAST;
                    if (!cmd_ok) begin
                        cmd_reject <= 1'b1;
                        state <= drc_pkg::DRC_IDLE;
                    end else if (lc.op == drc_pkg::DRC_ANTIRESONANCE_CMD && lc.has_arg) begin
                        ar_enable <= lc.arg[0];
                        ar_nv_wr <= 1'b1;
                        cmd_done <= 1'b1;
                        state <= drc_pkg::DRC_IDLE;
                    end else if (lc.op == drc_pkg::DRC_COPY_REGISTER_CMD
                        || lc.op == drc_pkg::DRC_NV_LOAD_CMD
                        || lc.op == drc_pkg::DRC_NV_STORE_CMD) begin
                        nv_wr <= lc.op == drc_pkg::DRC_NV_STORE_CMD;
                        cmd_done <= 1'b1;
                        state <= drc_pkg::DRC_IDLE;
                    end else begin
                        state <= drc_pkg::DRC_HDR_R;
                    end
                end
                drc_pkg::DRC_HDR_R: begin
                    if (free) begin
                        tx_data <= drc_pkg::CH_R;
                        tx_valid <= 1'b1;
                        state <= drc_pkg::DRC_HDR_X;
                    end
                end
                drc_pkg::DRC_HDR_X: begin
                    if (free) begin
                        tx_data <= drc_pkg::drc_op_char(lc.op);
                        tx_valid <= 1'b1;
                        state <= (lc.op == drc_pkg::DRC_BLOCK_UPLOAD_CMD)
                            ? drc_pkg::DRC_NAME : drc_pkg::DRC_EQ;
                    end
                end
                drc_pkg::DRC_NAME: begin
                    if (free) begin
                        tx_valid <= 1'b1;
                        name_idx <= name_idx + 2'h1;
                        if (!numeric) begin
                            tx_data <= name_char;
                            state <= drc_pkg::DRC_EQ;
                        end else if (name_idx == 2'h0) begin
                            tx_data <= drc_pkg::CH_ZERO;
                        end else if (name_idx == 2'h1) begin
                            tx_data <= code_tens;
                        end else begin
                            tx_data <= code_ones;
                            state <= drc_pkg::DRC_EQ;
                        end
                    end
                end
                drc_pkg::DRC_EQ: begin
                    if (free) begin
                        tx_data <= drc_pkg::CH_EQ;
                        tx_valid <= 1'b1;
                        state <= (lc.op == drc_pkg::DRC_STATUS_QUERY_CMD)
                            ? drc_pkg::DRC_STAT : drc_pkg::DRC_VAL;
                    end
                end
                drc_pkg::DRC_VAL: begin
                    if (fmt_take) begin
                        tx_data <= fmt_ch;
                        tx_valid <= 1'b1;
                    end else if (!fmt_busy) begin
                        state <= drc_pkg::DRC_CR;
                    end
                end
                drc_pkg::DRC_STAT: begin
                    if (!st_vec[stat_idx] || free) begin
                        if (st_vec[stat_idx]) begin
                            tx_data <= drc_pkg::drc_stat_char(stat_idx);
                            tx_valid <= 1'b1;
                        end
                        stat_idx <= stat_idx - 4'h1;
                        if (stat_idx == 4'h0) begin
                            state <= drc_pkg::DRC_CR;
                        end
                    end
                end
                drc_pkg::DRC_CR: begin
                    if (free) begin
                        tx_data <= drc_pkg::CH_CR;
                        tx_valid <= 1'b1;
                        name_idx <= 2'h0;
                        if (lc.op == drc_pkg::DRC_BLOCK_UPLOAD_CMD && left > 5'h1) begin
                            cur <= cur + 6'h1;
                            left <= left - 5'h1;
                            state <= drc_pkg::DRC_HDR_R;
                        end else begin
                            cmd_done <= 1'b1;
                            state <= drc_pkg::DRC_IDLE;
                        end
                    end
                end
                default: state <= drc_pkg::DRC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence copy_exec_s;
        exec && cmd_ok && lc.op == drc_pkg::DRC_COPY_REGISTER_CMD;
    endsequence
    sequence upload_exec_s;
        exec && lc.op == drc_pkg::DRC_BLOCK_UPLOAD_CMD;
    endsequence
    copy_move_a: assert property (copy_exec_s |=> regs[$past(ib)] == $past(copy_val))
        else $error("copy did not reach destination");
    copy_dest_a: assert property (exec && lc.op == drc_pkg::DRC_COPY_REGISTER_CMD
        && lc.reg_b < 8'h40 && RO_MASK[ib] |=> cmd_reject)
        else $error("read-only destination accepted");
    ar_set_a: assert property (exec && cmd_ok && lc.op == drc_pkg::DRC_ANTIRESONANCE_CMD
        && lc.has_arg |=> ar_enable == $past(lc.arg[0]) && ar_nv_wr)
        else $error("anti-resonance setting not applied");
    nv_load_a: assert property (exec && cmd_ok && lc.op == drc_pkg::DRC_NV_LOAD_CMD
        |=> regs[$past(ia)] == $past(load_val))
        else $error("load value not placed");
    short_fit_a: assert property (copy_exec_s and SHORT_MASK[ib]
        |=> regs[$past(ib)][31:16] == {16{regs[$past(ib)][15]}})
        else $error("short register upper word wrong");
    stat_char_a: assert property (state == drc_pkg::DRC_STAT && st_vec[stat_idx] && free
        |=> tx_valid && tx_data == drc_pkg::drc_stat_char($past(stat_idx)))
        else $error("status character mismatch");
    upload_cnt_a: assert property (upload_exec_s and lc.arg > drc_pkg::UPLOAD_MAX
        |=> cmd_reject && state == drc_pkg::DRC_IDLE)
        else $error("oversized upload accepted");
    reading_cr_a: assert property (state == drc_pkg::DRC_CR && free
        |=> tx_valid && tx_data == drc_pkg::CH_CR)
        else $error("reading not ended by carriage return");
    reject_a: assert property (exec && !cmd_ok |=> cmd_reject ##1 !cmd_reject && !tx_valid)
        else $error("bad command not rejected cleanly");
    hdr_a: assert property (state == drc_pkg::DRC_HDR_R && free
        |=> tx_data == drc_pkg::CH_R ##[1:8] tx_data == drc_pkg::drc_op_char(lc.op))
        else $error("reply header wrong");
endmodule : drc_handler

// ### hdl/drc_pkg.sv
// Package with the shared constants and types of the drive register command handler.
package drc_pkg;

    // ------------------------------------------------------------------
    // Sizes and ranges
    // ------------------------------------------------------------------
    localparam int NREG = 64;
    localparam int IW = 6;
    localparam int NV_DEPTH = 100;
    localparam logic [31:0] NV_LOC_MIN = 32'h1;
    localparam logic [31:0] NV_LOC_MAX = 32'h64;
    localparam logic [31:0] UPLOAD_MIN = 32'h1;
    localparam logic [31:0] UPLOAD_MAX = 32'h10;
    localparam int OPT_NUMERIC_BIT = 5;
    localparam int NSTAT = 12;
    localparam logic [31:0] AR_RESET = 32'h1;
    localparam logic [31:0] REG_RESET = 32'h0;
    localparam logic [3:0] STAT_LAST = 4'hB;

    // ------------------------------------------------------------------
    // Characters
    // ------------------------------------------------------------------
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_EQ = 8'h3D;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_MINUS = 8'h2D;

    // ------------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DRC_COPY_REGISTER_CMD = 3'h0,
        DRC_ANTIRESONANCE_CMD = 3'h1,
        DRC_NV_LOAD_CMD = 3'h2,
        DRC_STATUS_QUERY_CMD = 3'h3,
        DRC_BLOCK_UPLOAD_CMD = 3'h4,
        DRC_FIRMWARE_VERSION_CMD = 3'h5,
        DRC_NV_STORE_CMD = 3'h6
    } drc_op_t;

    typedef enum logic [3:0] {
        DRC_IDLE = 4'h0,
        DRC_EXEC = 4'h1,
        DRC_HDR_R = 4'h2,
        DRC_HDR_X = 4'h3,
        DRC_NAME = 4'h4,
        DRC_EQ = 4'h5,
        DRC_VAL = 4'h6,
        DRC_STAT = 4'h7,
        DRC_CR = 4'h8
    } drc_state_t;

    typedef struct packed {
        drc_op_t op;
        logic [7:0] reg_a;
        logic [7:0] reg_b;
        logic [31:0] arg;
        logic has_arg;
    } drc_cmd_t;

    typedef struct packed {
        logic alarm;
        logic disabled;
        logic fault;
        logic moving;
        logic homing;
        logic jogging;
        logic motion;
        logic in_pos;
        logic ready;
        logic stopping;
        logic wait_time;
        logic wait_input;
    } drc_status_t;

    // ------------------------------------------------------------------
    // Lookup functions
    // ------------------------------------------------------------------
    function automatic logic [7:0] drc_op_char(input drc_op_t op);
        case (op)
            DRC_ANTIRESONANCE_CMD: drc_op_char = 8'h4F;
            DRC_STATUS_QUERY_CMD: drc_op_char = 8'h53;
            DRC_BLOCK_UPLOAD_CMD: drc_op_char = 8'h55;
            default: drc_op_char = 8'h56;
        endcase
    endfunction : drc_op_char

    function automatic logic [7:0] drc_stat_char(input logic [3:0] idx);
        case (idx)
            4'hB: drc_stat_char = 8'h41;
            4'hA: drc_stat_char = 8'h44;
            4'h9: drc_stat_char = 8'h45;
            4'h8: drc_stat_char = 8'h46;
            4'h7: drc_stat_char = 8'h48;
            4'h6: drc_stat_char = 8'h4A;
            4'h5: drc_stat_char = 8'h4D;
            4'h4: drc_stat_char = 8'h50;
            4'h3: drc_stat_char = 8'h52;
            4'h2: drc_stat_char = 8'h53;
            4'h1: drc_stat_char = 8'h54;
            default: drc_stat_char = 8'h57;
        endcase
    endfunction : drc_stat_char

    function automatic logic [31:0] drc_pow10(input logic [3:0] p);
        case (p)
            4'h0: drc_pow10 = 32'h1;
            4'h1: drc_pow10 = 32'hA;
            4'h2: drc_pow10 = 32'h64;
            4'h3: drc_pow10 = 32'h3E8;
            4'h4: drc_pow10 = 32'h2710;
            4'h5: drc_pow10 = 32'h186A0;
            4'h6: drc_pow10 = 32'hF4240;
            4'h7: drc_pow10 = 32'h989680;
            4'h8: drc_pow10 = 32'h5F5E100;
            default: drc_pow10 = 32'h3B9ACA00;
        endcase
    endfunction : drc_pow10

endpackage : drc_pkg

// ### testbench/drc_host_model.sv
// Host model that collects reply characters and can stall the reply stream.
`timescale 1ns/100ps
module drc_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic stall,
    output logic tx_ready
);
    string rx = "";
    logic [1:0] cnt = 2'h0;
    initial tx_ready = 1'b1;
    // When stalling, the host accepts one cycle in four.
    always @(negedge ref_clk) begin
        cnt <= cnt + 2'h1;
        tx_ready <= !(stall && cnt != 2'h0);
    end
    always @(posedge ref_clk) begin
        if (tx_valid && tx_ready) begin
            rx = {rx, string'(tx_data)};
        end
    end
endmodule : drc_host_model

// ### testbench/test_drive_register_command_handler.sv
// Self-checking testbench of the drive register command handler.
`timescale 1ns/100ps
module test_drive_register_command_handler;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    logic stall = 1'b0;
    logic saw_wr = 1'b0;
    logic [15:0] host_option = 16'h0;
    logic [5:0] dbg_idx = 6'h0;
    logic cmd_ready, tx_valid, tx_ready, cmd_done, cmd_reject, ar_enable, ar_nv_wr, nv_wr;
    logic [7:0] tx_data;
    logic [31:0] dbg_data;
    drc_pkg::drc_cmd_t cmd = '0;
    drc_pkg::drc_status_t status = '0;
    int fail_count = 0;
    int check_count = 0;
    drc_handler dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .status(status), .host_option(host_option),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd_done(cmd_done),
        .cmd_reject(cmd_reject), .ar_enable(ar_enable), .ar_nv_wr(ar_nv_wr), .nv_wr(nv_wr),
        .dbg_idx(dbg_idx), .dbg_data(dbg_data));
    drc_host_model host (.ref_clk(ref_clk), .tx_data(tx_data), .tx_valid(tx_valid),
        .stall(stall), .tx_ready(tx_ready));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic stop_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input string seen, input string exp);
        check_count++;
        if (seen != exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %s seen %s", what, exp, seen);
        end
    endtask : check
    task automatic peek(input logic [5:0] idx, input logic [31:0] exp);
        @(negedge ref_clk);
        dbg_idx = idx;
        @(negedge ref_clk);
        check("register", $sformatf("%h", dbg_data), $sformatf("%h", exp));
    endtask : peek
    // Issues one command, waits for its end and judges done versus reject.
    task automatic run(input drc_pkg::drc_op_t op, input logic [7:0] a, input logic [7:0] b,
            input logic [31:0] arg, input logic has, input logic exp_rej);
        int n;
        logic rej;
        host.rx = "";
        saw_wr = 1'b0;
        rej = 1'b0;
        @(negedge ref_clk);
        cmd = '{op, a, b, arg, has};
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 2000 && cmd_done !== 1'b1 && !rej; n++) begin
            @(negedge ref_clk);
            rej = cmd_reject;
            saw_wr = saw_wr | ar_nv_wr | nv_wr;
        end
        while (tx_valid === 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 2000) begin
            fail_count++;
        end
        check("reject", $sformatf("%b", rej), $sformatf("%b", exp_rej));
    endtask : run
    task automatic t_antires();
        run(drc_pkg::DRC_ANTIRESONANCE_CMD, 8'h0, 8'h0, 32'h0, 1'b1, 1'b0);
        check("ar_enable", $sformatf("%b%b", ar_enable, saw_wr), "01");
        run(drc_pkg::DRC_ANTIRESONANCE_CMD, 8'h0, 8'h0, 32'h0, 1'b0, 1'b0);
        check("ar reply", host.rx, "RO=0\r");
        run(drc_pkg::DRC_ANTIRESONANCE_CMD, 8'h0, 8'h0, 32'h2, 1'b1, 1'b1);
        check("ar kept", $sformatf("%b%b", ar_enable, saw_wr), "00");
        run(drc_pkg::DRC_ANTIRESONANCE_CMD, 8'h0, 8'h0, 32'h1, 1'b1, 1'b0);
        check("ar_enable", $sformatf("%b", ar_enable), "1");
    endtask : t_antires
    task automatic t_status();
        stall = 1'b1;
        status = 12'hE19;
        run(drc_pkg::DRC_STATUS_QUERY_CMD, 8'h0, 8'h0, 32'h0, 1'b0, 1'b0);
        check("status reply", host.rx, "RS=ADEPRW\r");
        status = 12'h1E6;
        run(drc_pkg::DRC_STATUS_QUERY_CMD, 8'h0, 8'h0, 32'h0, 1'b0, 1'b0);
        check("status reply", host.rx, "RS=FHJMST\r");
        stall = 1'b0;
        status = '0;
    endtask : t_status
    task automatic t_upload();
        run(drc_pkg::DRC_BLOCK_UPLOAD_CMD, 8'h0, 8'h0, 32'h2, 1'b1, 1'b0);
        check("upload reply", host.rx, "RU0=0\rRU1=0\r");
        host_option = 16'h0020;
        run(drc_pkg::DRC_BLOCK_UPLOAD_CMD, 8'h11, 8'h0, 32'h1, 1'b1, 1'b0);
        check("upload reply", host.rx, "RU017=0\r");
        host_option = 16'h0;
        run(drc_pkg::DRC_BLOCK_UPLOAD_CMD, 8'h0, 8'h0, 32'h11, 1'b1, 1'b1);
        run(drc_pkg::DRC_BLOCK_UPLOAD_CMD, 8'h0, 8'h0, 32'h0, 1'b1, 1'b1);
        check("reject silent", host.rx, "");
        run(drc_pkg::DRC_FIRMWARE_VERSION_CMD, 8'h0, 8'h0, 32'h0, 1'b0, 1'b0);
        check("version reply", host.rx, "RV=100\r");
    endtask : t_upload
    task automatic t_registers();
        run(drc_pkg::DRC_COPY_REGISTER_CMD, 8'h0, 8'h1, 32'h0, 1'b0, 1'b0);
        peek(6'h1, 32'h0);
        run(drc_pkg::DRC_COPY_REGISTER_CMD, 8'h30, 8'h30, 32'h0, 1'b0, 1'b1);
        run(drc_pkg::DRC_NV_STORE_CMD, 8'h1, 8'h0, 32'h64, 1'b1, 1'b0);
        check("nv write", $sformatf("%b", saw_wr), "1");
        run(drc_pkg::DRC_NV_STORE_CMD, 8'h1, 8'h0, 32'h65, 1'b1, 1'b1);
        check("nv write", $sformatf("%b", saw_wr), "0");
        run(drc_pkg::DRC_NV_LOAD_CMD, 8'h2, 8'h0, 32'h64, 1'b1, 1'b0);
        peek(6'h2, 32'h0);
        run(drc_pkg::DRC_NV_LOAD_CMD, 8'h3C, 8'h0, 32'h1, 1'b1, 1'b1);
        run(drc_pkg::DRC_NV_LOAD_CMD, 8'h2, 8'h0, 32'h0, 1'b1, 1'b1);
    endtask : t_registers
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        check("ar reset", $sformatf("%b%b", ar_enable, cmd_ready), "11");
        t_antires();
        t_status();
        t_upload();
        t_registers();
        stop_test();
    end
endmodule : test_drive_register_command_handler
